// file: rsa_pkg.sv
package rsa_pkg;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned REG_W    = 4;
   localparam int unsigned NUM_REGS = 16;
   localparam int unsigned IMM_W    = 8;
   localparam int unsigned ROT_W    = 4;
   localparam int unsigned AMT_W    = 6;
   localparam int unsigned COND_W   = 4;

   localparam logic [5:0] SHIFT_MAX_REG = 6'h20;
   localparam logic [5:0] SHIFT_MAX_IMM = 6'h1f;
   localparam logic [5:0] SHIFT_MIN     = 6'h01;

   localparam logic [REG_W-1:0] PROG_COUNTER_INDEX = 4'hf;
   localparam logic [REG_W-1:0] LINK_INDEX         = 4'he;
   localparam logic [REG_W-1:0] STACK_PTR_INDEX    = 4'hd;

   localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      RSA_SH_ASL = 3'h0,
      RSA_SH_LSL = 3'h1,
      RSA_SH_LSR = 3'h2,
      RSA_SH_ASR = 3'h3,
      RSA_SH_ROR = 3'h4
   } rsa_shift_t;

   typedef enum logic [1:0]
   {
      RSA_OP_REG_SHIFT = 2'h0,
      RSA_OP_IMM_SHIFT = 2'h1,
      RSA_OP_ROT_CARRY = 2'h2,
      RSA_OP_IMM_ROT   = 2'h3
   } rsa_opform_t;

   typedef enum logic [1:0]
   {
      RSA_ST_IDLE  = 2'b00,
      RSA_ST_EXEC  = 2'b01,
      RSA_ST_WRITE = 2'b11
   } rsa_state_t;

   localparam logic [COND_W-1:0] COND_EQ = 4'h0;
   localparam logic [COND_W-1:0] COND_NE = 4'h1;
   localparam logic [COND_W-1:0] COND_CS = 4'h2;
   localparam logic [COND_W-1:0] COND_CC = 4'h3;
   localparam logic [COND_W-1:0] COND_MI = 4'h4;
   localparam logic [COND_W-1:0] COND_PL = 4'h5;
   localparam logic [COND_W-1:0] COND_VS = 4'h6;
   localparam logic [COND_W-1:0] COND_VC = 4'h7;
   localparam logic [COND_W-1:0] COND_HI = 4'h8;
   localparam logic [COND_W-1:0] COND_LS = 4'h9;
   localparam logic [COND_W-1:0] COND_GE = 4'ha;
   localparam logic [COND_W-1:0] COND_LT = 4'hb;
   localparam logic [COND_W-1:0] COND_GT = 4'hc;
   localparam logic [COND_W-1:0] COND_LE = 4'hd;
   localparam logic [COND_W-1:0] COND_AL = 4'he;
   localparam logic [COND_W-1:0] COND_NV = 4'hf;
endpackage : rsa_pkg

// file: rsa_shifter.sv
`timescale 1ns/10ps
module rsa_shifter
(
   input  wire logic [31:0]         value,
   input  wire logic [5:0]          amount,
   input  wire rsa_pkg::rsa_shift_t kind,
   input  wire logic                carry_in,
   output logic      [31:0]         result,
   output logic                     carry_out
);
   logic [63:0] wide;
   logic [4:0]  rot;

   always_comb
   begin
      wide      = 64'h0;
      rot       = amount[4:0];
      result    = value;
      carry_out = carry_in;
      if (amount != 6'h00)
      begin
         case (kind)
            rsa_pkg::RSA_SH_ASL,
            rsa_pkg::RSA_SH_LSL:
            begin
               wide      = {32'h0, value} << amount;
               result    = wide[31:0];
               carry_out = wide[32];
            end
            rsa_pkg::RSA_SH_LSR:
            begin
               wide      = {value, 32'h0} >> amount;
               result    = wide[63:32];
               carry_out = wide[31];
            end
            rsa_pkg::RSA_SH_ASR:
            begin
               wide      = $signed({value, 32'h0}) >>> amount;
               result    = wide[63:32];
               carry_out = wide[31];
            end
            rsa_pkg::RSA_SH_ROR:
            begin
               // a rotate by 32 leaves the word as is but moves bit 31 out
               wide      = {value, value} >> rot;
               result    = wide[31:0];
               carry_out = result[31];
            end
            default:
            begin
               result    = value;
               carry_out = carry_in;
            end
         endcase
      end
   end
endmodule : rsa_shifter

// file: rsa_cond.sv
`timescale 1ns/10ps
module rsa_cond
(
   input  wire logic [3:0] cond,
   input  wire logic       flag_n,
   input  wire logic       flag_z,
   input  wire logic       flag_c,
   input  wire logic       flag_v,
   output logic            pass
);
   always_comb
   begin
      case (cond)
         rsa_pkg::COND_EQ: pass = flag_z;
         rsa_pkg::COND_NE: pass = !flag_z;
         rsa_pkg::COND_CS: pass = flag_c;
         rsa_pkg::COND_CC: pass = !flag_c;
         rsa_pkg::COND_MI: pass = flag_n;
         rsa_pkg::COND_PL: pass = !flag_n;
         rsa_pkg::COND_VS: pass = flag_v;
         rsa_pkg::COND_VC: pass = !flag_v;
         rsa_pkg::COND_HI: pass = flag_c && !flag_z;
         rsa_pkg::COND_LS: pass = !flag_c || flag_z;
         rsa_pkg::COND_GE: pass = flag_n == flag_v;
         rsa_pkg::COND_LT: pass = flag_n != flag_v;
         rsa_pkg::COND_GT: pass = !flag_z && (flag_n == flag_v);
         rsa_pkg::COND_LE: pass = flag_z || (flag_n != flag_v);
         rsa_pkg::COND_AL: pass = 1'b1;
         default:          pass = 1'b0;
      endcase
   end
endmodule : rsa_cond

// file: rsa_alu.sv
// Function
// - reverse subtract is normal subtract with operand roles swapped
// - reverse subtract writes flexible operand minus first source, 32 bits
// - with borrow: flexible minus first source minus one plus carry
// - carry acts as inverted borrow: clear carry subtracts an extra one
// - both forms can update negative, zero, carry and overflow flags
// - flags update only with the set-flags option, else unchanged
// - instruction executes only when its condition field is satisfied
// - flexible operand: reg shift reg, reg shift imm, carry rotate, rotated imm
// - shifter offers asl, lsl, lsr, asr and ror
// - register-held shift counts from one through thirty-two accepted
// - immediate shift counts from one through thirty-one accepted
// - immediate operand is 8 bits rotated into a 32-bit word
// - destination and first source may be any of sixteen registers
// - borrow form chains upper words after a lower reverse subtract
`timescale 1ns/10ps
module rsa_alu
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                issue,
   input  wire logic                with_borrow,
   input  wire logic                set_flags,
   input  wire logic [3:0]          cond,
   input  wire logic [3:0]          dest_reg,
   input  wire logic [3:0]          first_source_register,
   input  wire rsa_pkg::rsa_opform_t op_form,
   input  wire logic [3:0]          shifted_operand_register,
   input  wire logic [3:0]          shift_amount_register,
   input  wire rsa_pkg::rsa_shift_t shift_kind,
   input  wire logic [4:0]          shift_imm,
   input  wire logic [7:0]          imm_value,
   input  wire logic [3:0]          imm_rotate,
   input  wire logic                load_en,
   input  wire logic [3:0]          load_reg,
   input  wire logic [31:0]         load_data,
   input  wire logic [3:0]          peek_reg,
   output logic                     busy,
   output logic                     done,
   output logic                     executed,
   output logic                     bad_shift,
   output logic [31:0]              result,
   output logic [31:0]              peek_data,
   output logic                     flag_n,
   output logic                     flag_z,
   output logic                     flag_c,
   output logic                     flag_v
);
   localparam int unsigned W = rsa_pkg::DATA_W;

   // one write port for both the load path and the alu result
   logic [W-1:0] regs_q [rsa_pkg::NUM_REGS];
   logic [W-1:0] regs_d [rsa_pkg::NUM_REGS];

   rsa_pkg::rsa_state_t state_q;
   rsa_pkg::rsa_state_t state_d;
   logic          n_q, z_q, c_q, v_q;
   logic          n_d, z_d, c_d, v_d;
   logic [W-1:0]  res_q, res_d;
   logic [W-1:0]  peek_q, peek_d;
   logic          done_q, done_d;
   logic          exec_q, exec_d;
   logic          bad_q, bad_d;
   logic          busy_q, busy_d;

   // latched instruction
   logic          brw_q, brw_d;
   logic          sf_q, sf_d;
   logic [3:0]    cond_q, cond_d;
   logic [3:0]    rd_q, rd_d;
   logic [3:0]    src_q, src_d;
   rsa_pkg::rsa_opform_t form_q, form_d;
   logic [3:0]    opd_q, opd_d;
   logic [3:0]    amr_q, amr_d;
   rsa_pkg::rsa_shift_t kind_q, kind_d;
   logic [4:0]    simm_q, simm_d;
   logic [7:0]    imm_q, imm_d;
   logic [3:0]    rot_q, rot_d;

   logic [W-1:0]  sh_in, sh_out, flex;
   logic [5:0]    sh_amt;
   logic          cond_ok;
   logic [W:0]    diff;
   logic          amt_bad;

   function automatic logic [W-1:0] rot_imm(input logic [7:0] v,
                                            input logic [3:0] r);
      logic [2*W-1:0] dbl;
      dbl     = {24'h0, v, 24'h0, v} >> {r, 1'b0};
      rot_imm = dbl[W-1:0];
   endfunction : rot_imm

   rsa_shifter u_shift
   (
      .value     (sh_in),
      .amount    (sh_amt),
      .kind      (kind_q),
      .carry_in  (c_q),
      .result    (sh_out),
      // subtract carry comes from the adder, so shifter carry stays open
      .carry_out ()
   );

   rsa_cond u_cond
   (
      .cond   (cond_q),
      .flag_n (n_q),
      .flag_z (z_q),
      .flag_c (c_q),
      .flag_v (v_q),
      .pass   (cond_ok)
   );

   // flexible operand forming
   always_comb
   begin
      sh_in   = regs_q[opd_q];
      sh_amt  = 6'h00;
      amt_bad = 1'b0;
      flex    = sh_in;
      case (form_q)
         rsa_pkg::RSA_OP_REG_SHIFT:
         begin
            // only the low six bits of the count register are honoured
            sh_amt  = regs_q[amr_q][5:0];
            amt_bad = (sh_amt < rsa_pkg::SHIFT_MIN) ||
                      (sh_amt > rsa_pkg::SHIFT_MAX_REG);
            flex    = sh_out;
         end
         rsa_pkg::RSA_OP_IMM_SHIFT:
         begin
            sh_amt  = {1'b0, simm_q};
            amt_bad = (sh_amt < rsa_pkg::SHIFT_MIN) ||
                      (sh_amt > rsa_pkg::SHIFT_MAX_IMM);
            flex    = sh_out;
         end
         rsa_pkg::RSA_OP_ROT_CARRY:
            flex = {c_q, sh_in[W-1:1]};
         rsa_pkg::RSA_OP_IMM_ROT:
            flex = rot_imm(imm_q, rot_q);
         default:
            flex = sh_in;
      endcase
   end

   // flexible operand is the minuend; carry in stands for not-borrow
   always_comb
   begin
      diff = {1'b0, flex} + {1'b0, ~regs_q[src_q]} +
             {{W{1'b0}}, (brw_q ? c_q : 1'b1)};
   end

   always_comb
   begin
      state_d = state_q;
      regs_d  = regs_q;
      n_d     = n_q;
      z_d     = z_q;
      c_d     = c_q;
      v_d     = v_q;
      res_d   = res_q;
      done_d  = 1'b0;
      exec_d  = exec_q;
      bad_d   = bad_q;
      peek_d  = regs_q[peek_reg];
      brw_d   = brw_q;
      sf_d    = sf_q;
      cond_d  = cond_q;
      rd_d    = rd_q;
      src_d   = src_q;
      form_d  = form_q;
      opd_d   = opd_q;
      amr_d   = amr_q;
      kind_d  = kind_q;
      simm_d  = simm_q;
      imm_d   = imm_q;
      rot_d   = rot_q;
      if (load_en && (state_q == rsa_pkg::RSA_ST_IDLE))
      begin
         regs_d[load_reg] = load_data;
      end
      case (state_q)
         rsa_pkg::RSA_ST_IDLE:
         begin
            if (issue)
            begin
               brw_d   = with_borrow;
               sf_d    = set_flags;
               cond_d  = cond;
               rd_d    = dest_reg;
               src_d   = first_source_register;
               form_d  = op_form;
               opd_d   = shifted_operand_register;
               amr_d   = shift_amount_register;
               kind_d  = shift_kind;
               simm_d  = shift_imm;
               imm_d   = imm_value;
               rot_d   = imm_rotate;
               state_d = rsa_pkg::RSA_ST_EXEC;
            end
         end
         rsa_pkg::RSA_ST_EXEC:
         begin
            exec_d  = cond_ok && !amt_bad;
            bad_d   = amt_bad;
            state_d = rsa_pkg::RSA_ST_WRITE;
            if (cond_ok && !amt_bad)
            begin
               res_d        = diff[W-1:0];
               regs_d[rd_q] = diff[W-1:0];
               if (sf_q)
               begin
                  n_d = diff[W-1];
                  z_d = (diff[W-1:0] == '0);
                  c_d = diff[W];
                  v_d = (flex[W-1] != regs_q[src_q][W-1]) &&
                        (diff[W-1] != flex[W-1]);
               end
            end
         end
         rsa_pkg::RSA_ST_WRITE:
         begin
            done_d  = 1'b1;
            state_d = rsa_pkg::RSA_ST_IDLE;
         end
         default:
            state_d = rsa_pkg::RSA_ST_IDLE;
      endcase
      // busy leaves a flop so the output carries no decode glitch
      busy_d = (state_d != rsa_pkg::RSA_ST_IDLE);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < rsa_pkg::NUM_REGS; i++)
         begin
            regs_q[i] <= rsa_pkg::REG_RESET;
         end
         state_q <= rsa_pkg::RSA_ST_IDLE;
         busy_q  <= 1'b0;
         n_q     <= 1'b0;
         z_q     <= 1'b0;
         c_q     <= 1'b0;
         v_q     <= 1'b0;
         res_q   <= rsa_pkg::REG_RESET;
         peek_q  <= rsa_pkg::REG_RESET;
         done_q  <= 1'b0;
         exec_q  <= 1'b0;
         bad_q   <= 1'b0;
         brw_q   <= 1'b0;
         sf_q    <= 1'b0;
         cond_q  <= rsa_pkg::COND_AL;
         rd_q    <= 4'h0;
         src_q   <= 4'h0;
         form_q  <= rsa_pkg::RSA_OP_REG_SHIFT;
         opd_q   <= 4'h0;
         amr_q   <= 4'h0;
         kind_q  <= rsa_pkg::RSA_SH_LSL;
         simm_q  <= 5'h00;
         imm_q   <= 8'h00;
         rot_q   <= 4'h0;
      end
      else
      begin
         regs_q  <= regs_d;
         state_q <= state_d;
         busy_q  <= busy_d;
         n_q     <= n_d;
         z_q     <= z_d;
         c_q     <= c_d;
         v_q     <= v_d;
         res_q   <= res_d;
         peek_q  <= peek_d;
         done_q  <= done_d;
         exec_q  <= exec_d;
         bad_q   <= bad_d;
         brw_q   <= brw_d;
         sf_q    <= sf_d;
         cond_q  <= cond_d;
         rd_q    <= rd_d;
         src_q   <= src_d;
         form_q  <= form_d;
         opd_q   <= opd_d;
         amr_q   <= amr_d;
         kind_q  <= kind_d;
         simm_q  <= simm_d;
         imm_q   <= imm_d;
         rot_q   <= rot_d;
      end
   end

   assign busy      = busy_q;
   assign done      = done_q;
   assign executed  = exec_q;
   assign bad_shift = bad_q;
   assign result    = res_q;
   assign peek_data = peek_q;
   assign flag_n    = n_q;
   assign flag_z    = z_q;
   assign flag_c    = c_q;
   assign flag_v    = v_q;
endmodule : rsa_alu

// file: rsa_alu_props.sv
`timescale 1ns/10ps
module rsa_alu_props
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        issue,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        executed,
   input wire logic        bad_shift,
   input wire logic [31:0] result,
   input wire logic        flag_n,
   input wire logic        flag_z,
   input wire logic        flag_c,
   input wire logic        flag_v
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_take_busy: assert property (issue && !busy |=> busy)
      else $error("instruction not taken while idle");
   a_done_bound: assert property (issue && !busy |-> ##[1:4] done)
      else $error("done did not follow a taken instruction");
   a_done_pulse: assert property (done |=> !done)
      else $error("done held longer than one cycle");
   a_done_idle: assert property (done |-> !busy)
      else $error("busy still high with done");
   a_flag_hold: assert property
      (!busy |=> $stable({flag_n, flag_z, flag_c, flag_v}))
      else $error("flags moved while idle");
   a_result_hold: assert property (!busy |=> $stable(result))
      else $error("result moved while idle");
   a_zero_flag: assert property
      ($changed(flag_z) |-> flag_z == (result == 32'h0))
      else $error("zero flag disagrees with result");
   a_neg_flag: assert property ($changed(flag_n) |-> flag_n == result[31])
      else $error("negative flag disagrees with result");
   a_bad_noexec: assert property (bad_shift |-> !executed)
      else $error("bad shift count still executed");
endmodule : rsa_alu_props

bind rsa_alu rsa_alu_props u_props
(
   .clock     (clock),
   .rst_n     (rst_n),
   .issue     (issue),
   .busy      (busy),
   .done      (done),
   .executed  (executed),
   .bad_shift (bad_shift),
   .result    (result),
   .flag_n    (flag_n),
   .flag_z    (flag_z),
   .flag_c    (flag_c),
   .flag_v    (flag_v)
);

// file: rsa_tb.sv
`timescale 1ns/10ps
module testbench;
   logic        clock, rst_n, issue, with_borrow, set_flags, load_en;
   logic [3:0]  cond, dest_reg, first_source_register, load_reg, peek_reg;
   logic [3:0]  shifted_operand_register, shift_amount_register, imm_rotate;
   logic [4:0]  shift_imm;
   logic [7:0]  imm_value;
   logic [31:0] load_data, peek_data, result;
   logic        busy, done, executed, bad_shift;
   logic        flag_n, flag_z, flag_c, flag_v;
   rsa_pkg::rsa_opform_t op_form;
   rsa_pkg::rsa_shift_t  shift_kind;
   int          err_total, cmp_count, cyc;

   rsa_alu DUT
   (
      .clock                    (clock),
      .rst_n                    (rst_n),
      .issue                    (issue),
      .with_borrow              (with_borrow),
      .set_flags                (set_flags),
      .cond                     (cond),
      .dest_reg                 (dest_reg),
      .first_source_register    (first_source_register),
      .op_form                  (op_form),
      .shifted_operand_register (shifted_operand_register),
      .shift_amount_register    (shift_amount_register),
      .shift_kind               (shift_kind),
      .shift_imm                (shift_imm),
      .imm_value                (imm_value),
      .imm_rotate               (imm_rotate),
      .load_en                  (load_en),
      .load_reg                 (load_reg),
      .load_data                (load_data),
      .peek_reg                 (peek_reg),
      .busy                     (busy),
      .done                     (done),
      .executed                 (executed),
      .bad_shift                (bad_shift),
      .result                   (result),
      .peek_data                (peek_data),
      .flag_n                   (flag_n),
      .flag_z                   (flag_z),
      .flag_c                   (flag_c),
      .flag_v                   (flag_v)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic ld(input logic [3:0] r, input logic [31:0] v);
      @(posedge clock);
      load_en <= 1'b1;
      load_reg <= r;
      load_data <= v;
      @(posedge clock);
      load_en <= 1'b0;
   endtask : ld

   // iv packs the rotate amount above the 8-bit immediate
   task automatic op(input int b, s, input logic [3:0] c, d, n,
                     input logic [1:0] f, input logic [3:0] m,
                     input logic [2:0] k, input logic [4:0] si,
                     input logic [11:0] iv, input logic [31:0] er,
                     input logic [3:0] ef, input logic [1:0] eb);
      int t;
      @(posedge clock);
      with_borrow <= b[0];
      set_flags <= s[0];
      cond <= c;
      dest_reg <= d;
      first_source_register <= n;
      op_form <= rsa_pkg::rsa_opform_t'(f);
      shifted_operand_register <= m;
      shift_kind <= rsa_pkg::rsa_shift_t'(k);
      shift_imm <= si;
      imm_rotate <= iv[11:8];
      imm_value <= iv[7:0];
      issue <= 1'b1;
      @(posedge clock);
      issue <= 1'b0;
      #1;
      chk(32'(busy), 32'h1);
      t = 0;
      while (done !== 1'b1 && t < 8)
      begin
         @(posedge clock);
         #1;
         t++;
      end
      chk(32'(done), 32'h1);
      chk(result, er);
      chk(32'({flag_n, flag_z, flag_c, flag_v}), 32'(ef));
      chk(32'({bad_shift, executed}), 32'(eb));
      chk(32'(busy), 32'h0);
   endtask : op

   task automatic t_shift_kinds();
      logic [31:0] ex [5] = '{32'h130, 32'h130, 32'h0800_0001,
                              32'hf800_0001, 32'h3800_0001};
      ld(4'h2, 32'h8000_0013);
      for (int k = 0; k < 5; k++)
         op(0, 0, 4'he, 4'h4, 4'h0, 2'h1, 4'h2, 3'(k), 5'h4, 12'h0,
            ex[k], 4'h0, 2'b01);
   endtask : t_shift_kinds

   task automatic t_rot_imm();
      ld(4'hf, 32'h1000);
      peek_reg <= 4'hf;
      op(0, 1, 4'he, 4'hf, 4'hf, 2'h3, 4'h0, 3'h0, 5'h0, 12'h4ea,
         32'he9ff_f000, 4'b1010, 2'b01);
      chk(peek_data, 32'he9ff_f000);
   endtask : t_rot_imm

   task automatic t_multiword();
      ld(4'h6, 32'h1);
      ld(4'h7, 32'h2);
      ld(4'h9, 32'h1);
      op(0, 1, 4'he, 4'h6, 4'h6, 2'h3, 4'h0, 3'h0, 5'h0, 12'h000,
         32'hffff_ffff, 4'b1000, 2'b01);
      op(1, 1, 4'he, 4'h7, 4'h7, 2'h3, 4'h0, 3'h0, 5'h0, 12'h5ff,
         32'h3fbf_fffd, 4'b0010, 2'b01);
      op(1, 1, 4'he, 4'h8, 4'h0, 2'h3, 4'h0, 3'h0, 5'h0, 12'h001,
         32'h1, 4'b0010, 2'b01);
      op(0, 1, 4'he, 4'h8, 4'h8, 2'h3, 4'h0, 3'h0, 5'h0, 12'h001,
         32'h0, 4'b0110, 2'b01);
      op(0, 1, 4'he, 4'h9, 4'h9, 2'h3, 4'h0, 3'h0, 5'h0, 12'h102,
         32'h7fff_ffff, 4'b0011, 2'b01);
   endtask : t_multiword

   // flags are n=0 z=0 c=1 v=1 here; bit i says whether code i passes
   task automatic t_conds();
      logic [15:0] pass = 16'h6966;
      logic [31:0] last = 32'h7fff_ffff;
      for (int c = 0; c < 16; c++)
      begin
         if (pass[c])
            last = 32'(c);
         op(0, 0, 4'(c), 4'h9, 4'h0, 2'h3, 4'h0, 3'h0, 5'h0, 12'(c),
            last, 4'b0011, {1'b0, pass[c]});
      end
   endtask : t_conds

   task automatic t_rot_carry();
      op(0, 0, 4'he, 4'h4, 4'h0, 2'h2, 4'h2, 3'h0, 5'h0, 12'h0,
         32'hc000_0009, 4'b0011, 2'b01);
   endtask : t_rot_carry

   task automatic t_counts();
      logic [31:0] cnt [4] = '{32'h0, 32'h1, 32'h20, 32'h21};
      logic [31:0] ex [4] = '{32'hc000_0009, 32'h4000_0009, 32'h0, 32'h0};
      logic [1:0]  eb [4] = '{2'b10, 2'b01, 2'b01, 2'b10};
      for (int i = 0; i < 4; i++)
      begin
         ld(4'h3, cnt[i]);
         op(0, 0, 4'he, 4'h4, 4'h0, 2'h0, 4'h2, 3'h2, 5'h0, 12'h0,
            ex[i], 4'b0011, eb[i]);
      end
      op(0, 0, 4'he, 4'h4, 4'h0, 2'h1, 4'h2, 3'h2, 5'h1f, 12'h0,
         32'h1, 4'b0011, 2'b01);
      op(0, 0, 4'he, 4'h4, 4'h0, 2'h1, 4'h2, 3'h2, 5'h0, 12'h0,
         32'h1, 4'b0011, 2'b10);
   endtask : t_counts

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial
   begin
      {rst_n, issue, with_borrow, set_flags, load_en} = 5'h0;
      {cond, dest_reg, first_source_register, load_reg} = 16'h0;
      {shifted_operand_register, imm_rotate, peek_reg} = 12'h0;
      shift_amount_register = 4'h3;
      shift_imm = 5'h0;
      imm_value = 8'h0;
      load_data = 32'h0;
      op_form = rsa_pkg::RSA_OP_IMM_ROT;
      shift_kind = rsa_pkg::RSA_SH_LSL;
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_shift_kinds();
      t_rot_imm();
      t_multiword();
      t_conds();
      t_rot_carry();
      t_counts();
      tally_and_finish();
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
endmodule : testbench
